// ==== erb_pkg.sv ====
// Package for the receive ring buffer: register map, limits, carriers
package erb_pkg;
  // Memory geometry
  localparam int          ERB_AW        = 15;
  localparam logic [14:0] ERB_MEM_LAST  = 15'h5fff;
  localparam int          ERB_MEM_WORDS = 24576;
  localparam int          ERB_HDR_LEN   = 8;
  // Register byte addresses (Wishbone, one word each)
  localparam logic [4:0]  ERB_OFF_START = 5'h00;
  localparam logic [4:0]  ERB_OFF_TAIL  = 5'h04;
  localparam logic [4:0]  ERB_OFF_HEADL = 5'h08;
  localparam logic [4:0]  ERB_OFF_HEADH = 5'h0c;
  localparam logic [4:0]  ERB_OFF_CTRL  = 5'h10;
  localparam logic [4:0]  ERB_OFF_STAT  = 5'h14;
  // Control and status field positions
  localparam int          ERB_CTRL_RECEIVE_ENABLE_BIT = 0;
  localparam int          ERB_CTRL_DEC  = 8;
  localparam int          ERB_STAT_PEND = 6;
  // Reset values and count limit
  localparam logic [14:0] ERB_START_RST = 15'h0000;
  localparam logic [14:0] ERB_TAIL_RST  = 15'h5ffe;
  localparam logic [7:0]  ERB_CNT_MAX   = 8'hff;

  // Byte from the MAC
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic       reject;
    logic [7:0] data;
  } erb_rx_byte_t;

  // One memory write port
  typedef struct packed {
    logic        we;
    logic [14:0] addr;
    logic [7:0]  data;
  } erb_mem_wr_t;

  // Wrap-aware increment inside the ring
  function automatic logic [14:0] erb_inc(input logic [14:0] a, input logic [14:0] start);
    erb_inc = (a == ERB_MEM_LAST) ? start : a + 15'h0001;
  endfunction
endpackage

// ==== erb_mem.sv ====
// Packet SRAM with one write port and one read port
`timescale 1ns/1ps
module erb_mem
  import erb_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Write side
  input  wire erb_mem_wr_t wr_i,
  // Read side
  input  wire logic [14:0] rd_addr_i,
  output logic      [7:0]  rd_data_o
);
  logic [7:0] mem_q [ERB_MEM_WORDS];
  logic [7:0] rd_q;

  // Synchronous write and read
  always_ff @(posedge clk_i) begin
    if (wr_i.we) begin
      mem_q[wr_i.addr] <= wr_i.data;
    end
    rd_q <= mem_q[rd_addr_i];
  end

  assign rd_data_o = rd_q;
endmodule

// ==== erb_wb_regs.sv ====
// Wishbone classic slave holding the software-side registers
`timescale 1ns/1ps
module erb_wb_regs
  import erb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Block state
  input  wire logic [14:0] head_i,
  input  wire logic [7:0]  count_i,
  input  wire logic        dec_busy_i,
  // Controls
  output logic      [14:0] start_o,
  output logic      [14:0] tail_o,
  output logic             receive_enable_bit_o,
  output logic             start_wr_o,
  output logic             dec_req_o
);
  logic [14:0] start_q, start_d, tail_q, tail_d;
  logic [6:0]  shadow_q, shadow_d;
  logic        receive_enable_bit_q, receive_enable_bit_d, ack_q, ack_d, swr_q, swr_d, dec_q, dec_d;
  logic [31:0] dat_q, dat_d;
  logic        acc;

  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;

  // Decode, write and read
  always_comb begin
    start_d  = start_q;
    tail_d   = tail_q;
    shadow_d = shadow_q;
    receive_enable_bit_d   = receive_enable_bit_q;
    ack_d    = acc;
    swr_d    = 1'b0;
    dec_d    = 1'b0;
    dat_d    = 32'h0000_0000;
    if (acc && wb_we_i) begin
      case (wb_adr_i)
        ERB_OFF_START: begin
          if (wb_sel_i[0]) start_d[7:0] = {wb_dat_i[7:1], 1'b0};
          if (wb_sel_i[1]) start_d[14:8] = wb_dat_i[14:8];
          swr_d = |wb_sel_i[1:0];
        end
        ERB_OFF_TAIL: begin
          if (wb_sel_i[0]) tail_d[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) tail_d[14:8] = wb_dat_i[14:8];
        end
        ERB_OFF_CTRL: begin
          if (wb_sel_i[0]) receive_enable_bit_d = wb_dat_i[ERB_CTRL_RECEIVE_ENABLE_BIT];
          if (wb_sel_i[1]) dec_d = wb_dat_i[ERB_CTRL_DEC];
        end
        default: begin
        end
      endcase
    end else if (acc) begin
      case (wb_adr_i)
        ERB_OFF_START: dat_d = {17'h00000, start_q};
        ERB_OFF_TAIL:  dat_d = {17'h00000, tail_q};
        ERB_OFF_HEADL: begin
          dat_d    = {24'h000000, head_i[7:0]};
          shadow_d = head_i[14:8];
        end
        ERB_OFF_HEADH: dat_d = {25'h0000000, shadow_q};
        ERB_OFF_CTRL:  dat_d = {23'h000000, dec_busy_i, 7'h00, receive_enable_bit_q};
        ERB_OFF_STAT:  dat_d = {16'h0000, 1'b0, |count_i, 6'h00, count_i};
        default:       dat_d = 32'h0000_0000;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q  <= ERB_START_RST;
      tail_q   <= ERB_TAIL_RST;
      shadow_q <= 7'h00;
      receive_enable_bit_q   <= 1'b0;
      ack_q    <= 1'b0;
      swr_q    <= 1'b0;
      dec_q    <= 1'b0;
      dat_q    <= 32'h0000_0000;
    end else begin
      start_q  <= start_d;
      tail_q   <= tail_d;
      shadow_q <= shadow_d;
      receive_enable_bit_q   <= receive_enable_bit_d;
      ack_q    <= ack_d;
      swr_q    <= swr_d;
      dec_q    <= dec_d;
      dat_q    <= dat_d;
    end
  end

  assign wb_dat_o   = dat_q;
  assign wb_ack_o   = ack_q;
  assign start_o    = start_q;
  assign tail_o     = tail_q;
  assign receive_enable_bit_o     = receive_enable_bit_q;
  assign start_wr_o = swr_q;
  assign dec_req_o  = dec_q;
endmodule

// ==== erb_rx_ring.sv ====
// Receive ring buffer top: frame writer, head/tail, pending count
`timescale 1ns/1ps
// Overview of operation
// - Ring from start address to 5fff
// - Frames begin on even addresses
// - Write pointer equal tail means full
// - Overrun or reject rolls head back
// - Count increments per accepted frame
// - Count overflow discards frame too
// - Head is read-only to software
// - Head low read latches high shadow
// - Start write reloads head
// - Tail checked on data bytes only, not on the 8 header bytes
// - Accept frames only while enabled
// - Store frame bytes as received
// - Next pointer then six-byte status
// - Pending flag while count nonzero
// - Decrement bit lowers count, self-clears
module erb_rx_ring
  import erb_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Wishbone
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [4:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // MAC receive byte stream
  input  wire erb_rx_byte_t rx_i,
  input  wire logic [31:0]  rx_status_vector_i,
  // Host memory read port
  input  wire logic [14:0]  host_rd_addr_i,
  output logic      [7:0]   host_rd_data_o,
  // Status
  output logic              frame_pending_flag_o,
  output logic              frame_dropped_o
);
  typedef enum {ST_IDLE, ST_DATA, ST_HDR, ST_DROP} erb_state_t;

  erb_state_t  state_q, state_d;
  logic [14:0] head_q, head_d, wptr_q, wptr_d;
  logic [15:0] len_q, len_d;
  logic [2:0]  hidx_q, hidx_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [47:0] hdr_q, hdr_d;
  logic        pend_q, pend_d, drop_q, drop_d;
  erb_mem_wr_t wr_d, wr_q;

  logic [14:0] start_w, tail_w, nxt_w;
  logic        receive_enable_bit_w, start_wr_w, dec_w;
  logic [7:0]  rd_w;

  // Software registers
  erb_wb_regs u_regs (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wb_cyc_i   (wb_cyc_i),
    .wb_stb_i   (wb_stb_i),
    .wb_we_i    (wb_we_i),
    .wb_adr_i   (wb_adr_i),
    .wb_sel_i   (wb_sel_i),
    .wb_dat_i   (wb_dat_i),
    .wb_dat_o   (wb_dat_o),
    .wb_ack_o   (wb_ack_o),
    .head_i     (head_q),
    .count_i    (cnt_q),
    .dec_busy_i (|cnt_q),
    .start_o    (start_w),
    .tail_o     (tail_w),
    .receive_enable_bit_o     (receive_enable_bit_w),
    .start_wr_o (start_wr_w),
    .dec_req_o  (dec_w)
  );

  // Packet storage
  erb_mem u_mem (
    .clk_i     (clk_i),
    .wr_i      (wr_q),
    .rd_addr_i (host_rd_addr_i),
    .rd_data_o (rd_w)
  );

  assign nxt_w = erb_inc(wptr_q, start_w);

  // Frame writer state machine, pointers and counter
  always_comb begin
    state_d = state_q;
    head_d  = head_q;
    wptr_d  = wptr_q;
    len_d   = len_q;
    hidx_d  = hidx_q;
    hdr_d   = hdr_q;
    cnt_d   = cnt_q;
    drop_d  = 1'b0;
    wr_d    = '0;
    case (state_q)
      ST_IDLE: begin
        if (rx_i.valid && rx_i.sof && receive_enable_bit_w) begin
          wptr_d = head_q;
          for (int i = 0; i < ERB_HDR_LEN; i++) begin
            wptr_d = erb_inc(wptr_d, start_w);
          end
          len_d   = 16'h0000;
          state_d = ST_DATA;
          if (wptr_d == tail_w) begin
            state_d = rx_i.eof ? ST_IDLE : ST_DROP;
            drop_d  = 1'b1;
          end else begin
            wr_d.we   = 1'b1;
            wr_d.addr = wptr_d;
            wr_d.data = rx_i.data;
            len_d     = 16'h0001;
            wptr_d    = erb_inc(wptr_d, start_w);
            if (rx_i.eof) begin
              state_d = ST_HDR;
            end
          end
        end
      end
      ST_DATA: begin
        if (rx_i.valid) begin
          if (wptr_q == tail_w) begin
            state_d = rx_i.eof ? ST_IDLE : ST_DROP;
            drop_d  = 1'b1;
          end else begin
            wr_d.we   = 1'b1;
            wr_d.addr = wptr_q;
            wr_d.data = rx_i.data;
            len_d     = len_q + 16'h0001;
            wptr_d    = nxt_w;
            if (rx_i.eof) begin
              state_d = ST_HDR;
            end
          end
        end
      end
      ST_HDR: begin
        if (hidx_q == 3'h0) begin
          if (rx_i.reject || cnt_q == ERB_CNT_MAX) begin
            state_d = ST_IDLE;
            drop_d  = 1'b1;
          end else begin
            if (wptr_q[0]) begin
              wptr_d = nxt_w;
            end
            hdr_d = {rx_status_vector_i[31:16], len_q, 1'b0, wptr_d};
          end
        end
        if (state_d == ST_HDR) begin
          wr_d.we   = 1'b1;
          wr_d.addr = head_q + {12'h000, hidx_q};
          if (head_q + {12'h000, hidx_q} > ERB_MEM_LAST) begin
            wr_d.addr = start_w + (head_q + {12'h000, hidx_q} - ERB_MEM_LAST - 15'h0001);
          end
          hidx_d    = hidx_q + 3'h1;
          if (hidx_q == 3'h0) begin
            wr_d.data = wptr_d[7:0];
          end else if (hidx_q == 3'h1) begin
            wr_d.data = {1'b0, hdr_q[14:8]};
          end else if (hidx_q < 3'h6) begin
            // Length bytes, then status bits 31:16
            wr_d.data = hdr_q[8 * int'(hidx_q) +: 8];
          end else begin
            // Last two status bytes carry nothing yet
            wr_d.data = 8'h00;
          end
          if (hidx_q == 3'h7) begin
            head_d  = wptr_q;
            cnt_d   = cnt_q + 8'h01;
            hidx_d  = 3'h0;
            state_d = ST_IDLE;
          end
        end
      end
      ST_DROP: begin
        if (rx_i.valid && rx_i.eof) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (drop_d) begin
      hidx_d = 3'h0;
    end
    if (dec_w && cnt_d != 8'h00) begin
      cnt_d = cnt_d - 8'h01;
    end
    if (start_wr_w) begin
      head_d  = start_w;
      state_d = ST_IDLE;
      hidx_d  = 3'h0;
      wr_d    = '0;
    end
  end

  assign pend_d = (cnt_d != 8'h00);

  // Register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      head_q  <= ERB_START_RST;
      wptr_q  <= ERB_START_RST;
      len_q   <= 16'h0000;
      hidx_q  <= 3'h0;
      hdr_q   <= 48'h0;
      cnt_q   <= 8'h00;
      pend_q  <= 1'b0;
      drop_q  <= 1'b0;
      wr_q    <= '0;
    end else begin
      state_q <= state_d;
      head_q  <= head_d;
      wptr_q  <= wptr_d;
      len_q   <= len_d;
      hidx_q  <= hidx_d;
      hdr_q   <= hdr_d;
      cnt_q   <= cnt_d;
      pend_q  <= pend_d;
      drop_q  <= drop_d;
      wr_q    <= wr_d;
    end
  end

  // Host read data is a registered SRAM output
  assign host_rd_data_o       = rd_w;
  assign frame_pending_flag_o = pend_q;
  assign frame_dropped_o      = drop_q;
endmodule

// ==== erb_ring_chk_properties.sv ====
// Port-level checks for the receive ring top
`timescale 1ns/1ps
module erb_ring_chk
  import erb_pkg::*;
(
  // Clock and reset
  input wire logic         clk_i,
  input wire logic         rst_i,
  // Wishbone
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic [4:0]   wb_adr_i,
  input wire logic [31:0]  wb_dat_o,
  input wire logic         wb_ack_o,
  // Stream and status
  input wire erb_rx_byte_t rx_i,
  input wire logic         frame_pending_flag_o,
  input wire logic         frame_dropped_o
);
  logic [3:0] since_eof_q;
  logic [3:0] since_eof_d;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles since a frame end, saturating so idle time never wraps
  always_comb begin
    since_eof_d = (since_eof_q == 4'hf) ? since_eof_q : since_eof_q + 4'h1;
    if (rx_i.valid && rx_i.eof) begin
      since_eof_d = 4'h0;
    end
  end
  always_ff @(posedge clk_i) begin
    since_eof_q <= rst_i ? 4'hf : since_eof_d;
  end
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_HEADL_FMT: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == ERB_OFF_HEADL |-> wb_dat_o[31:8] == 24'h0)
    else $error("head low wide");
  AST_HEADH_FMT: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == ERB_OFF_HEADH |-> wb_dat_o[31:7] == 25'h0)
    else $error("head high wide");
  AST_STAT_FMT: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == ERB_OFF_STAT
    |-> wb_dat_o[31:15] == 17'h0 && wb_dat_o[13:8] == 6'h0 && wb_dat_o[14] == (wb_dat_o[7:0] != 8'h0))
    else $error("status word bad");
  AST_REJECT_DROP: assert property (
    rx_i.valid && rx_i.eof && rx_i.reject |-> ##[1:12] frame_dropped_o)
    else $error("reject not dropped");
  AST_DROP_PULSE: assert property (frame_dropped_o |=> !frame_dropped_o)
    else $error("drop held");
  AST_PEND_RISE: assert property ($rose(frame_pending_flag_o) |-> since_eof_q <= 4'd12)
    else $error("pending rose without frame");
  AST_PEND_FALL: assert property (
    $fell(frame_pending_flag_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("pending fell without write");
endmodule

bind erb_rx_ring erb_ring_chk i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rx_i(rx_i), .frame_pending_flag_o(frame_pending_flag_o), .frame_dropped_o(frame_dropped_o)
);

// ==== erb_mac_model.sv ====
// Behavioural MAC byte source feeding the ring
`timescale 1ns/1ps
module erb_mac_model
  import erb_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Stream toward the ring
  output erb_rx_byte_t     rx_o,
  output logic      [31:0] rx_status_vector_o
);
  initial begin
    rx_o = '0;
    rx_status_vector_o = 32'h0;
  end
  // bytes only
  // Frame bytes, then idle with toggling data so no stale byte reads as real
  task automatic send(input logic [7:0] len, input logic [7:0] base, input logic rej);
    rx_status_vector_o <= {8'h0, len, 16'h0};
    for (int i = 0; i < len; i++) begin
      @(posedge clk_i);
      rx_o <= '{valid: 1'b1, sof: (i == 0), eof: (i == len - 1), reject: rej, data: base + 8'(i)};
    end
    // Reject held through the header cycles; next start is 12 cycles after the last byte
    repeat (10) begin
      @(posedge clk_i);
      rx_o <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, reject: rej, data: ~rx_o.data};
    end
    @(posedge clk_i);
    rx_o.reject <= 1'b0;
  endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the receive ring buffer
`timescale 1ns/1ps
module testbench
  import erb_pkg::*;
;
  logic         clk_i;
  logic         rst_i;
  logic         wb_cyc_i;
  logic         wb_stb_i;
  logic         wb_we_i;
  logic [4:0]   wb_adr_i;
  logic [31:0]  wb_dat_i;
  logic [31:0]  wb_dat_o;
  logic         wb_ack_o;
  erb_rx_byte_t rx_b;
  logic [31:0]  rx_status_vector;
  logic [14:0]  host_rd_addr_i;
  logic [7:0]   host_rd_data_o;
  logic         pend;
  logic         dropped;
  logic [31:0]  rd;
  int           errors;
  int           n_compared;
  int           cycles;

  erb_rx_ring i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_i(rx_b), .rx_status_vector_i(rx_status_vector), .host_rd_addr_i(host_rd_addr_i),
    .host_rd_data_o(host_rd_data_o), .frame_pending_flag_o(pend), .frame_dropped_o(dropped)
  );
  erb_mac_model i_mac (.clk_i(clk_i), .rx_o(rx_b), .rx_status_vector_o(rx_status_vector));

  // 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      test_done;
    end
  end

  task automatic test_done;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic w(input logic [4:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask
  // Memory data lands one cycle after the address
  task automatic mchk(input logic [14:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    host_rd_addr_i <= a;
    repeat (2) @(posedge clk_i);
    chk({24'h0, host_rd_data_o}, {24'h0, exp});
  endtask

  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 5'h00;
    wb_dat_i = 32'h0;
    host_rd_addr_i = 15'h0000;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset state and unmapped place
    rchk(ERB_OFF_TAIL, 32'h5ffe);
    rchk(ERB_OFF_STAT, 32'h0);
    w(5'h18, 32'hffff);
    rchk(5'h18, 32'h0);
    w(ERB_OFF_START, 32'h0100);
    rchk(ERB_OFF_HEADL, 32'h00);
    rchk(ERB_OFF_HEADH, 32'h01);
    w(ERB_OFF_HEADL, 32'h55);
    rchk(ERB_OFF_HEADL, 32'h00);
    i_mac.send(8'd5, 8'h10, 1'b0);
    rchk(ERB_OFF_STAT, 32'h0);
    w(ERB_OFF_CTRL, 32'h1);
    i_mac.send(8'd5, 8'h10, 1'b0);
    rchk(ERB_OFF_STAT, 32'h4001);
    chk({31'h0, pend}, 32'h1);
    mchk(15'h0100, 8'h0e);
    mchk(15'h0101, 8'h01);
    mchk(15'h0102, 8'h05);
    for (int i = 0; i < 5; i++)
      mchk(15'h0108 + 15'(i), 8'h10 + 8'(i));
    i_mac.send(8'd4, 8'h30, 1'b1);
    rchk(ERB_OFF_STAT, 32'h4001);
    // Low byte first, head then crosses a page
    rchk(ERB_OFF_HEADL, 32'h0e);
    i_mac.send(8'd242, 8'h00, 1'b0);
    rchk(ERB_OFF_HEADH, 32'h01);
    rchk(ERB_OFF_HEADL, 32'h08);
    rchk(ERB_OFF_HEADH, 32'h02);
    w(ERB_OFF_CTRL, 32'h101);
    rchk(ERB_OFF_CTRL, 32'h101);
    w(ERB_OFF_CTRL, 32'h101);
    rchk(ERB_OFF_CTRL, 32'h001);
    w(ERB_OFF_CTRL, 32'h101);
    rchk(ERB_OFF_STAT, 32'h0);
    // Small ring near the end of memory
    w(ERB_OFF_CTRL, 32'h0);
    w(ERB_OFF_START, 32'h5fe0);
    w(ERB_OFF_CTRL, 32'h1);
    i_mac.send(8'd14, 8'h20, 1'b0);
    w(ERB_OFF_TAIL, 32'h5ff4);
    i_mac.send(8'd10, 8'h40, 1'b0);
    rchk(ERB_OFF_HEADL, 32'he8);
    mchk(15'h5fff, 8'h41);
    mchk(15'h5fe0, 8'h42);
    mchk(15'h5ff6, 8'he8);
    i_mac.send(8'd20, 8'h60, 1'b0);
    rchk(ERB_OFF_HEADL, 32'he8);
    rchk(ERB_OFF_STAT, 32'h4002);
    mchk(15'h5ff4, 8'h2c);
    // Fill the count to its top, then one more
    w(ERB_OFF_CTRL, 32'h0);
    w(ERB_OFF_START, 32'h0000);
    w(ERB_OFF_TAIL, 32'h5ffe);
    w(ERB_OFF_CTRL, 32'h1);
    repeat (253) i_mac.send(8'd2, 8'h70, 1'b0);
    rchk(ERB_OFF_STAT, 32'h40ff);
    i_mac.send(8'd2, 8'h70, 1'b0);
    rchk(ERB_OFF_STAT, 32'h40ff);
    rchk(ERB_OFF_HEADL, 32'he2);
    rchk(ERB_OFF_HEADH, 32'h09);
    test_done;
  end
endmodule
